// ---- lane_mode_control.v ----
// Lane routing, equalizer, output and DDC buffer control for the retimer
`timescale 1ns/1ps
`include "lane_mode_map.vh"
// =====================================================
// Notes on behaviour
// - Swap maps input lanes, outputs fixed
// - Swap on strap low or control bit
// - Swap in both modes; EQ follows mapping
// - Polarity inversion only while retiming
// - Auto mode: inversion lost below threshold
// - Per data lane TMDS error counters
// - Strap high 14 dB, low 7.5, float adaptive
// - Adaptive only retimer; register selectable too (code: register mode always forces fixed gain, adaptive off)
// - Register field sets fixed gain all lanes
// - Four termination settings from register field
// - Outputs high impedance while enable low
// - De-emphasis from strap or register field
// - Retime above about 25 MHz pixel clock
// - Relock about 7 ms, drivers optional off
// - Function mode field; redriver powers off PLL
// - Redriver disables retiming
// - Source DDC forwarded after start condition
// - Sink data response driven to source
// - DDC rate default 100 kbps, selectable
// - Control inputs ignored while enable low
module lane_mode_control #(
  parameter LOCK_CYCLES = `LOCK_TIME_US * `CLK_MHZ,
  parameter CNT_W = 16
) (
  input wire clk,
  input wire reset_n,
  input wire clk_en,
  input wire output_enable,
  input wire swap_strap_n,
  input wire swap_reg,
  input wire polarity_reg,
  input wire [1:0] equalizer_select_strap,
  input wire eq_reg_mode,
  input wire [4:0] eq_gain_reg,
  input wire [1:0] source_termination_select,
  input wire deemph_strap_n,
  input wire i2c_mode,
  input wire [1:0] deemph_reg,
  input wire [1:0] function_mode_select,
  input wire drivers_off_lock,
  input wire pixel_clk,
  input wire [3:0] lane_in,
  input wire [2:0] tmds_error,
  input wire err_clear,
  input wire [7:0] ddc_rate_reg,
  input wire source_side_ddc_data,
  input wire source_side_ddc_clock,
  input wire sink_side_ddc_data,
  input wire sink_ready,
  output reg [3:0] lane_out,
  output reg lane_valid,
  output reg tmds_out_en,
  output reg retimer_active,
  output reg pll_power_on,
  output reg adaptive_eq,
  output reg [7:0] eq_gain,
  output reg [1:0] term_setting,
  output reg [1:0] deemph_setting,
  output reg [CNT_W-1:0] err_count_0,
  output reg [CNT_W-1:0] err_count_1,
  output reg [CNT_W-1:0] err_count_2,
  output reg sink_ddc_data_out,
  output reg sink_ddc_data_oe,
  output reg sink_ddc_clock_out,
  output reg sink_ddc_clock_oe,
  output reg source_ddc_data_out,
  output reg source_ddc_data_oe,
  output reg [7:0] ddc_rate
);
  // =====================================================
  // Input synchronisers, two stages each
  reg [11:0] s1_r;
  reg [11:0] s2_r;
  wire oe_s = s2_r[0];
  wire swap_n_s = s2_r[1];
  wire pclk_s = s2_r[2];
  wire source_side_ddc_data_s = s2_r[3];
  wire source_side_ddc_clock_s = s2_r[4];
  wire sink_side_ddc_data_s = s2_r[5];
  wire deemph_n_s = s2_r[6];
  wire [2:0] err_s = s2_r[9:7];
  // Only the second stage is ever read
  always @(posedge clk) begin
    if (!reset_n) begin
      s1_r <= 12'h87b;
      s2_r <= 12'h87b;
    end else if (clk_en) begin
      s1_r <= {equalizer_select_strap, tmds_error, deemph_strap_n, sink_side_ddc_data,
        source_side_ddc_clock, source_side_ddc_data, pixel_clk, swap_strap_n, output_enable};
      s2_r <= s1_r;
    end
  end
  // Gated strap input: held while enable low
  reg [1:0] eq_strap_r;
  always @(posedge clk) begin
    if (!reset_n) begin
      eq_strap_r <= `EQ_STRAP_FLOAT;
    end else if (clk_en && oe_s) begin
      eq_strap_r <= s2_r[11:10];
    end
  end
  // =====================================================
  // Pixel clock rate detector
  reg pclk_d_r;
  reg [15:0] win_r;
  reg [15:0] edges_r;
  reg fast_r;
  reg fast_d_r;
  wire pclk_rise = pclk_s & ~pclk_d_r;
  // Counts pixel clock edges in a fixed window of system clocks
  always @(posedge clk) begin
    if (!reset_n || !oe_s) begin
      pclk_d_r <= 1'b0;
      win_r <= 16'h0000;
      edges_r <= 16'h0000;
      fast_r <= 1'b0;
      fast_d_r <= 1'b0;
    end else if (clk_en) begin
      pclk_d_r <= pclk_s;
      fast_d_r <= fast_r;
      if (win_r == `RATE_WINDOW_CYC) begin
        win_r <= 16'h0000;
        edges_r <= 16'h0000;
        fast_r <= (edges_r >= (`RATE_THRESH >> 4));
      end else begin
        win_r <= win_r + 16'h0001;
        if (pclk_rise) begin
          edges_r <= edges_r + 16'h0001;
        end
      end
    end
  end
  // =====================================================
  // Mode state machine, one-hot
  localparam ST_REDRV = 3'b001;
  localparam ST_LOCK = 3'b010;
  localparam ST_RETIME = 3'b100;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [31:0] lock_cnt_r;
  wire want_retime = (function_mode_select == `FUNC_RETIMER) ||
                     ((function_mode_select == `FUNC_AUTO) && fast_r);
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_REDRV: begin
        if (want_retime) begin
          state_nxt = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if (!want_retime) begin
          state_nxt = ST_REDRV;
        end else if (lock_cnt_r >= LOCK_CYCLES - 1) begin
          state_nxt = ST_RETIME;
        end
      end
      ST_RETIME: begin
        if (!want_retime) begin
          state_nxt = ST_REDRV;
        end else if (fast_r != fast_d_r) begin
          state_nxt = ST_LOCK;
        end
      end
      default: state_nxt = ST_REDRV;
    endcase
  end
  // State register and lock timer
  always @(posedge clk) begin
    if (!reset_n || !oe_s) begin
      state_r <= ST_REDRV;
      lock_cnt_r <= 32'h00000000;
    end else if (clk_en) begin
      state_r <= state_nxt;
      if (state_r == ST_LOCK && state_nxt == ST_LOCK) begin
        lock_cnt_r <= lock_cnt_r + 32'h00000001;
      end else begin
        lock_cnt_r <= 32'h00000000;
      end
    end
  end
  wire retiming = (state_r == ST_RETIME);
  // =====================================================
  // Two-entry lane buffer
  reg [3:0] buf_mem [0:1];
  reg [1:0] buf_cnt_r;
  reg wr_ptr_r;
  reg rd_ptr_r;
  wire buf_empty = (buf_cnt_r == 2'h0);
  wire buf_full = (buf_cnt_r == 2'h2);
  wire swap_on = ~swap_n_s | swap_reg;
  // Remap inputs in order {clk, d2, d1, d0}; output positions are fixed
  function [3:0] route;
    input [3:0] d;
    input sw;
    begin
      route = sw ? {d[2], d[3], d[0], d[1]} : d;
    end
  endfunction
  wire pol_on = polarity_reg & retiming;
  wire [3:0] routed = route(lane_in, swap_on) ^ {4{pol_on}};
  wire push = oe_s & ~buf_full;
  wire pop = ~buf_empty & (~lane_valid | sink_ready);
  // Buffer: sink stall fills it, full refuses new words
  always @(posedge clk) begin
    if (!reset_n || !oe_s) begin
      buf_cnt_r <= 2'h0;
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      lane_out <= 4'h0;
      lane_valid <= 1'b0;
      buf_mem[0] <= 4'h0;
      buf_mem[1] <= 4'h0;
    end else if (clk_en) begin
      if (push) begin
        buf_mem[wr_ptr_r] <= routed;
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        lane_out <= buf_mem[rd_ptr_r];
        lane_valid <= 1'b1;
        rd_ptr_r <= ~rd_ptr_r;
      end else if (sink_ready) begin
        lane_valid <= 1'b0;
      end
      buf_cnt_r <= buf_cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
  // =====================================================
  // Error counters per data lane
  function [CNT_W-1:0] bump;
    input [CNT_W-1:0] c;
    input e;
    begin
      bump = (e && c != {CNT_W{1'b1}}) ? c + 1'b1 : c;
    end
  endfunction
  // Clear and error in one cycle: count restarts at one
  always @(posedge clk) begin
    if (!reset_n || !oe_s) begin
      err_count_0 <= {CNT_W{1'b0}};
      err_count_1 <= {CNT_W{1'b0}};
      err_count_2 <= {CNT_W{1'b0}};
    end else if (clk_en) begin
      err_count_0 <= bump(err_clear ? {CNT_W{1'b0}} : err_count_0, err_s[0]);
      err_count_1 <= bump(err_clear ? {CNT_W{1'b0}} : err_count_1, err_s[1]);
      err_count_2 <= bump(err_clear ? {CNT_W{1'b0}} : err_count_2, err_s[2]);
    end
  end
  // =====================================================
  // Output settings
  always @(posedge clk) begin
    if (!reset_n || !oe_s) begin
      tmds_out_en <= 1'b0;
      retimer_active <= 1'b0;
      pll_power_on <= 1'b0;
      adaptive_eq <= 1'b0;
      eq_gain <= `EQ_GAIN_LOW;
      term_setting <= 2'h0;
      deemph_setting <= `DEEMPH_0DB;
      ddc_rate <= `DDC_RATE_DEFAULT;
    end else if (clk_en) begin
      tmds_out_en <= ~((state_r == ST_LOCK) & drivers_off_lock);
      retimer_active <= retiming;
      pll_power_on <= (state_r != ST_REDRV);
      if (eq_reg_mode) begin
        adaptive_eq <= 1'b0;
        eq_gain <= {3'h0, eq_gain_reg};
      end else begin
        adaptive_eq <= (eq_strap_r == `EQ_STRAP_FLOAT) & (state_r != ST_REDRV);
        eq_gain <= (eq_strap_r == `EQ_STRAP_HIGH) ? `EQ_GAIN_HIGH : `EQ_GAIN_LOW;
      end
      term_setting <= source_termination_select;
      deemph_setting <= i2c_mode ? deemph_reg : (deemph_n_s ? `DEEMPH_0DB : `DEEMPH_2DB);
      ddc_rate <= ddc_rate_reg;
    end
  end
  // =====================================================
  // DDC buffer: forwards after a start on the source side
  reg source_side_ddc_data_d_r;
  reg active_r;
  reg src_echo_r, snk_echo_r; // Own low returns late through the sync; masked till line high
  always @(posedge clk) begin
    if (!reset_n || !oe_s) begin
      source_side_ddc_data_d_r <= 1'b1;
      active_r <= 1'b0;
      sink_ddc_data_out <= 1'b0;
      sink_ddc_data_oe <= 1'b0;
      sink_ddc_clock_out <= 1'b0;
      sink_ddc_clock_oe <= 1'b0;
      source_ddc_data_out <= 1'b0;
      source_ddc_data_oe <= 1'b0;
      src_echo_r <= 1'b0;
      snk_echo_r <= 1'b0;
    end else if (clk_en) begin
      source_side_ddc_data_d_r <= source_side_ddc_data_s;
      if (source_side_ddc_clock_s && source_side_ddc_data_d_r && !source_side_ddc_data_s) begin
        active_r <= 1'b1;
      end else if (source_side_ddc_clock_s && !source_side_ddc_data_d_r && source_side_ddc_data_s) begin
        active_r <= 1'b0;
      end
      // forward lows to the sink side
      sink_ddc_clock_oe <= active_r & ~source_side_ddc_clock_s;
      sink_ddc_data_oe <= active_r & ~source_side_ddc_data_s & ~source_ddc_data_oe & ~src_echo_r;
      // sink pulls low, echo to source
      source_ddc_data_oe <= active_r & ~sink_side_ddc_data_s & ~sink_ddc_data_oe & ~snk_echo_r;
      src_echo_r <= source_ddc_data_oe | (src_echo_r & ~source_side_ddc_data_s);
      snk_echo_r <= sink_ddc_data_oe | (snk_echo_r & ~sink_side_ddc_data_s);
    end
  end
endmodule // lane_mode_control

// ---- lane_mode_map.vh ----
// Constants for the lane mode control block
`ifndef LANE_MODE_MAP_VH
`define LANE_MODE_MAP_VH
// =====================================================
// Equalizer strap decode
`define EQ_STRAP_LOW 2'h0
`define EQ_STRAP_HIGH 2'h1
`define EQ_STRAP_FLOAT 2'h2
// Equalizer gain codes, tenths of dB
`define EQ_GAIN_HIGH 8'h8c
`define EQ_GAIN_LOW 8'h4b
// =====================================================
// Function mode field values
`define FUNC_AUTO 2'h0
`define FUNC_REDRIVER 2'h1
`define FUNC_RETIMER 2'h2
// =====================================================
// De-emphasis codes
`define DEEMPH_0DB 2'h0
`define DEEMPH_2DB 2'h1
// =====================================================
// Timing
`define CLK_MHZ 40
`define LOCK_TIME_US 7000
`define RATE_WINDOW_CYC 16'h0190
`define RATE_THRESH 16'h0fa0
// Default DDC rate code, 100 kbps
`define DDC_RATE_DEFAULT 8'h00
`endif

// ---- lane_mode_monitor.sv ----
// Checker of the lane mode control block ports
`timescale 1ns/1ps
`include "lane_mode_map.vh"
module lane_mode_monitor (
  input wire clk,
  input wire reset_n,
  input wire clk_en,
  input wire output_enable,
  input wire [1:0] equalizer_select_strap,
  input wire eq_reg_mode,
  input wire [4:0] eq_gain_reg,
  input wire [1:0] source_termination_select,
  input wire deemph_strap_n,
  input wire i2c_mode,
  input wire [1:0] deemph_reg,
  input wire [1:0] function_mode_select,
  input wire sink_ready,
  input wire [3:0] lane_out,
  input wire lane_valid,
  input wire tmds_out_en,
  input wire retimer_active,
  input wire pll_power_on,
  input wire adaptive_eq,
  input wire [7:0] eq_gain,
  input wire [1:0] term_setting,
  input wire [1:0] deemph_setting
);
  // ==========
  // Run qualifier: enable must outlast its two-flop sync first
  logic [2:0] up_r;
  wire run = (up_r == 3'h7) && clk_en && output_enable;
  always @(posedge clk) begin
    if (!reset_n || !output_enable) up_r <= 3'h0;
    else if (clk_en && up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  // ==========
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_oe_low_hiz: assert property (!output_enable [*4] |-> !tmds_out_en)
    else $error("tmds outputs driven while enable low");
  a_redrv_pll_off: assert property ((run && function_mode_select == `FUNC_REDRIVER) [*4]
    |-> !pll_power_on && !retimer_active) else $error("pll or retimer on in redriver");
  a_adapt_retimer_only: assert property ((run && function_mode_select == `FUNC_REDRIVER) [*4]
    |-> !adaptive_eq) else $error("adaptive eq in redriver");
  a_strap_gain_high: assert property ((run && !eq_reg_mode &&
    equalizer_select_strap == `EQ_STRAP_HIGH) [*5] |-> eq_gain == `EQ_GAIN_HIGH)
    else $error("strap high gain wrong");
  a_strap_gain_low: assert property ((run && !eq_reg_mode &&
    equalizer_select_strap == `EQ_STRAP_LOW) [*5] |-> eq_gain == `EQ_GAIN_LOW)
    else $error("strap low gain wrong");
  a_reg_gain_used: assert property ((run && eq_reg_mode && $stable(eq_gain_reg)) [*4]
    |-> eq_gain == {3'h0, eq_gain_reg}) else $error("register gain not applied");
  a_term_follows: assert property ((run && $stable(source_termination_select)) [*4]
    |-> term_setting == source_termination_select) else $error("termination mismatch");
  a_deemph_source: assert property ((run && $stable({i2c_mode, deemph_reg, deemph_strap_n})) [*5]
    |-> deemph_setting == (i2c_mode ? deemph_reg : (deemph_strap_n ? `DEEMPH_0DB : `DEEMPH_2DB)))
    else $error("de-emphasis mismatch");
  a_stall_hold: assert property (run && lane_valid && !sink_ready
    |=> lane_valid && $stable(lane_out)) else $error("word lost under stall");
  // Main scenarios reached
  c_lock: cover property (run && $rose(retimer_active));
  c_stall: cover property (lane_valid && !sink_ready);
  c_gain_high: cover property (eq_gain == `EQ_GAIN_HIGH);
endmodule // lane_mode_monitor
bind lane_mode_control lane_mode_monitor i_lane_mode_monitor (.*);

// ---- sink_partner.sv ----
// Far side model: downstream DDC responder and stalling receiver
`timescale 1ns/1ps
module sink_partner (
  input wire clk,
  input wire stall,
  input wire ack,
  input wire sink_ddc_data_oe,
  output logic sink_side_ddc_data,
  output logic sink_ready = 1'b1
);
  // ==========
  // Pulled-up wire: low while either party pulls it
  assign sink_side_ddc_data = !(sink_ddc_data_oe || ack);
  // Ready drops one edge after a stall, as a real receiver lags
  always @(posedge clk) begin
    sink_ready <= !stall;
  end
endmodule // sink_partner

// ---- tb_top.sv ----
// Self-checking bench for the lane mode control block
`timescale 1ns/1ps
`include "lane_mode_map.vh"
module tb_top;
  // ==========
  logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, output_enable = 1'b1, pixel_clk = 1'b0;
  logic swap_strap_n = 1'b1, swap_reg = 1'b0, polarity_reg = 1'b0, eq_reg_mode = 1'b0;
  logic deemph_strap_n = 1'b1, i2c_mode = 1'b0, drivers_off_lock = 1'b0, err_clear = 1'b0;
  logic scl_low = 1'b0, sda_low = 1'b0, stall = 1'b0, ack = 1'b0;
  logic [1:0] equalizer_select_strap = `EQ_STRAP_HIGH, source_termination_select = 2'h0;
  logic [1:0] deemph_reg = 2'h0, function_mode_select = `FUNC_REDRIVER;
  logic [4:0] eq_gain_reg = 5'h00;
  logic [3:0] lane_in = 4'h0;
  logic [2:0] tmds_error = 3'h0;
  logic [7:0] ddc_rate_reg = `DDC_RATE_DEFAULT;
  wire [3:0] lane_out;
  wire lane_valid, tmds_out_en, retimer_active, pll_power_on, adaptive_eq, sink_ready;
  wire sink_ddc_data_out, sink_ddc_data_oe, sink_ddc_clock_out, sink_ddc_clock_oe;
  wire source_ddc_data_out, source_ddc_data_oe, sink_side_ddc_data;
  wire [7:0] eq_gain, ddc_rate;
  wire [1:0] term_setting, deemph_setting;
  wire [15:0] err_count_0, err_count_1, err_count_2;
  // Source DDC lines are pulled up; the design only ever pulls low
  wire source_side_ddc_data = !(sda_low || source_ddc_data_oe);
  wire source_side_ddc_clock = !scl_low;
  int failures = 0, tests_run = 0;
  // Short lock count keeps the retimer scenario brief
  lane_mode_control #(.LOCK_CYCLES(20)) i_lane_mode_control (.*);
  sink_partner i_sink_partner (.*);
  initial forever #12.5 clk = ~clk;
  // Link clock of 200 ns, well under the retiming threshold
  initial forever #100 pixel_clk = ~pixel_clk;
  // ==========
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    if (failures == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function logic pick(input int s);
    return s == 0 ? retimer_active : s == 1 ? sink_ddc_clock_oe : source_ddc_data_oe;
  endfunction
  // Bounded wait; running out ends the run as a mismatch
  task waitc(input int s);
    for (int i = 0; i < 50 && pick(s) !== 1'b1; i++) cyc(1);
    if (pick(s) !== 1'b1) begin
      failures++;
      print_verdict();
    end
  endtask
  // Swapped order: d2 to clock slot, clock to d2, d1 and d0 exchanged
  function logic [3:0] swp(input logic [3:0] d);
    return {d[2], d[3], d[0], d[1]};
  endfunction
  // ==========
  task t_eq;
    cyc(6); chk(eq_gain, `EQ_GAIN_HIGH);
    equalizer_select_strap = `EQ_STRAP_LOW;
    cyc(6); chk(eq_gain, `EQ_GAIN_LOW);
    eq_reg_mode = 1'b1; eq_gain_reg = 5'h1f;
    cyc(6); chk(eq_gain, 16'h001f);
    eq_reg_mode = 1'b0;
  endtask
  task t_out;
    for (int i = 0; i < 4; i++) begin
      source_termination_select = i[1:0];
      cyc(6); chk(term_setting, i[1:0]);
    end
    chk(deemph_setting, `DEEMPH_0DB);
    deemph_strap_n = 1'b0;
    cyc(6); chk(deemph_setting, `DEEMPH_2DB);
    i2c_mode = 1'b1; deemph_reg = 2'h1;
    cyc(6); chk(deemph_setting, 2'h1);
  endtask
  task t_swap;
    lane_in = 4'h9;
    cyc(6); chk(lane_out, 4'h9);
    swap_strap_n = 1'b0;
    cyc(6); chk(lane_out, swp(4'h9));
    swap_strap_n = 1'b1; swap_reg = 1'b1; lane_in = 4'h4;
    cyc(6); chk(lane_out, swp(4'h4));
  endtask
  // Receiver stalls while the input keeps changing; held word must survive
  task t_stall;
    stall = 1'b1;
    cyc(3); lane_in = 4'h1; cyc(1); lane_in = 4'h2; cyc(2);
    chk(lane_out, swp(4'h4));
    chk(lane_valid, 1'b1);
    stall = 1'b0;
    cyc(8); chk(lane_out, swp(4'h2));
  endtask
  task t_retime;
    drivers_off_lock = 1'b1; function_mode_select = `FUNC_RETIMER;
    cyc(4); chk(tmds_out_en, 1'b0);
    waitc(0); chk(pll_power_on, 1'b1);
    cyc(2); chk(tmds_out_en, 1'b1);
    equalizer_select_strap = `EQ_STRAP_FLOAT;
    cyc(6); chk(adaptive_eq, 1'b1);
    polarity_reg = 1'b1;
    cyc(6); chk(lane_out, swp(4'h2) ^ 4'hf);
    function_mode_select = `FUNC_REDRIVER;
    cyc(8); chk(retimer_active, 1'b0);
    chk(adaptive_eq, 1'b0);
    chk(lane_out, swp(4'h2));
    function_mode_select = `FUNC_AUTO;
    cyc(900); chk(retimer_active, 1'b0);
    chk(lane_out, swp(4'h2));
    polarity_reg = 1'b0;
    equalizer_select_strap = `EQ_STRAP_LOW;
  endtask
  task t_err;
    err_clear = 1'b1; cyc(2); err_clear = 1'b0;
    tmds_error = 3'h2; cyc(5); tmds_error = 3'h0; cyc(5);
    chk(err_count_0, 16'h0000);
    chk(err_count_1, 16'h0005);
    chk(err_count_2, 16'h0000);
  endtask
  task t_ddc;
    chk(ddc_rate, `DDC_RATE_DEFAULT);
    ddc_rate_reg = 8'h01;
    cyc(3); chk(ddc_rate, 8'h01);
    sda_low = 1'b1; cyc(6); scl_low = 1'b1;
    waitc(1); chk(sink_ddc_data_oe, 1'b1);
    sda_low = 1'b0; cyc(8); ack = 1'b1;
    waitc(2); chk(source_ddc_data_oe, 1'b1);
    ack = 1'b0; sda_low = 1'b1; cyc(6); scl_low = 1'b0; cyc(6); sda_low = 1'b0;
    cyc(8); chk(sink_ddc_clock_oe, 1'b0);
    // After the stop a clock low alone must not be forwarded
    scl_low = 1'b1;
    cyc(8); chk(sink_ddc_clock_oe, 1'b0);
    scl_low = 1'b0;
    chk({sink_ddc_data_out, sink_ddc_clock_out, source_ddc_data_out}, 3'h0);
  endtask
  // Enable held low for 100 us, with inputs moving meanwhile
  task t_oe;
    output_enable = 1'b0; source_termination_select = 2'h2;
    cyc(4000); chk(tmds_out_en, 1'b0);
    chk(term_setting, 2'h0);
    chk(err_count_1, 16'h0000);
    output_enable = 1'b1;
    cyc(10); chk(tmds_out_en, 1'b1);
    chk(term_setting, 2'h2);
  endtask
  // ==========
  initial begin
    cyc(3);
    reset_n = 1'b1;
    t_eq; t_out; t_swap; t_stall; t_retime; t_err; t_ddc; t_oe;
    print_verdict();
  end
endmodule // tb_top
